// file: tb/tb_top.sv
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import umc_pkg::*;
  localparam logic [1:0] F_MODE = 2'h0;
  localparam logic F_HYSTERESIS_SELECT = 1'b1;
  localparam logic [5:0] F_LEVEL = 6'h2A;
  logic clk, nrst, cyc, stb, we, dbg, sw_rst, ack, freq, hold, cen, chy, rreq, irq;
  logic cout, frdy, srst, sbod;
  logic [7:0] adr;
  logic [5:0] supply, clev;
  logic [31:0] wdat, rdat, dato;
  int bad_count = 0;
  int compares = 0;
  always #50 clk = ~clk;
  umc_top i_dut (.CORE_CLK(clk), .NRST(nrst), .SYS_RST(srst), .SYS_RST_BOD(sbod),
    .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hF),
    .WB_DAT_I(wdat), .WB_DAT_O(dato), .WB_ACK_O(ack), .CMP_OUT(cout), .DBG_EN(dbg),
    .FUSE_RDY(frdy), .FUSE_MODE(F_MODE), .FUSE_HYSTERESIS_SELECT(F_HYSTERESIS_SELECT), .FUSE_LEVEL(F_LEVEL),
    .FUSE_REQ(freq), .CPU_HOLD(hold), .CMP_EN(cen), .CMP_HYSTERESIS_SELECT(chy), .CMP_LEVEL(clev),
    .BOD_RST_REQ(rreq), .IRQ(irq));
  umc_far_model i_far (.clk(clk), .supply(supply), .sw_rst(sw_rst), .cmp_en(cen),
    .cmp_hysteresis_select(chy), .cmp_level(clev), .fuse_req(freq), .bod_req(rreq), .cmp_out(cout),
    .fuse_rdy(frdy), .sys_rst(srst), .sys_rst_bod(sbod));
  ////////////////////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // The request stays up until ack is sampled, whatever the slave latency.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    rdat = dato;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    // The write acts at the ack edge, so callers look at outputs one edge later.
    @(posedge clk);
  endtask : wb
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0000_0000);
    chk(rdat, exp);
  endtask : rd
  task automatic ctrl_wr(input logic [31:0] d);
    wb(1'b1, ADR_UNLOCK, {UNLOCK_KEY, 16'h0000, ADR_CTRL});
    wb(1'b1, ADR_CTRL, d);
  endtask : ctrl_wr
  function automatic logic [31:0] cw(input logic [1:0] m, input logic h, input logic [5:0] l,
    input logic f, input logic z);
    cw = {z, 14'h0000, f, 6'h00, l, h, 1'b0, m};
  endfunction : cw
  task automatic report_and_stop;
    $display("comparisons %0d, mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : report_and_stop
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    tick(20000);
    bad_count++;
    report_and_stop();
  end
  initial begin
    clk = 1'b0;
    nrst = 1'b0;
    {cyc, stb, we, dbg, sw_rst} = 5'h00;
    adr = 8'h00;
    wdat = 32'h0000_0000;
    supply = 6'h3F;
    tick(10);
    nrst <= 1'b1;
    tick(10);
    chk(hold, 1'b0);
    chk(cen, 1'b0);
    rd(ADR_CTRL, cw(F_MODE, F_HYSTERESIS_SELECT, F_LEVEL, 1'b1, 1'b0));
    chk(clev, F_LEVEL);
    rd(8'h40, 32'h0000_0000);
    wb(1'b1, ADR_CTRL, cw(MODE_FLAG, 1'b0, 6'h10, 1'b0, 1'b0));
    rd(ADR_CTRL, cw(F_MODE, F_HYSTERESIS_SELECT, F_LEVEL, 1'b1, 1'b0));
    supply <= 6'h05;
    ctrl_wr(cw(MODE_FLAG, 1'b0, 6'h10, 1'b0, 1'b0));
    rd(ADR_STAT, 32'h0000_0002);
    chk({cen, chy, clev}, {2'b10, 6'h10});
    tick(50);
    rd(ADR_STAT, 32'h0000_0001);
    rd(ADR_ISR, 32'h0000_0001);
    chk(irq, 1'b0);
    wb(1'b1, ADR_IER, 32'h0000_0001);
    chk(irq, 1'b1);
    chk(rreq, 1'b0);
    supply <= 6'h11;
    tick(5);
    rd(ADR_STAT, 32'h0000_0000);
    wb(1'b1, ADR_ISR, 32'h0000_0001);
    chk(irq, 1'b0);
    ctrl_wr(cw(MODE_OFF, 1'b0, 6'h10, 1'b0, 1'b0));
    ctrl_wr(cw(MODE_FLAG, 1'b1, 6'h10, 1'b0, 1'b0));
    chk(chy, 1'b1);
    supply <= 6'h05;
    tick(50);
    chk(irq, 1'b1);
    wb(1'b1, ADR_IDR, 32'h0000_0001);
    chk(irq, 1'b0);
    rd(ADR_IMR, 32'h0000_0000);
    wb(1'b1, ADR_ISR, 32'h0000_0001);
    ctrl_wr(cw(MODE_OFF, 1'b0, 6'h10, 1'b0, 1'b0));
    dbg <= 1'b1;
    ctrl_wr(cw(MODE_RESET, 1'b0, 6'h20, 1'b0, 1'b1));
    tick(60);
    chk(rreq, 1'b0);
    rd(ADR_ISR, 32'h0000_0000);
    rd(ADR_STAT, 32'h0000_0001);
    ctrl_wr(cw(MODE_RESET, 1'b0, 6'h08, 1'b0, 1'b0));
    rd(ADR_CTRL, cw(MODE_RESET, 1'b0, 6'h20, 1'b1, 1'b1));
    dbg <= 1'b0;
    repeat (10) if (rreq !== 1'b1) @(posedge clk);
    chk(rreq, 1'b1);
    supply <= 6'h3F;
    tick(15);
    rd(ADR_CTRL, cw(MODE_RESET, 1'b0, 6'h20, 1'b1, 1'b1));
    sw_rst <= 1'b1;
    tick(1);
    sw_rst <= 1'b0;
    tick(2);
    chk(hold, 1'b1);
    tick(15);
    rd(ADR_CTRL, cw(F_MODE, F_HYSTERESIS_SELECT, F_LEVEL, 1'b1, 1'b0));
    chk(cen, 1'b0);
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire

// file: tb/umc_far_model.sv
`default_nettype none
module umc_far_model (
  input wire logic clk, // Core clock.
  input wire logic [5:0] supply, // Supply code set by the bench.
  input wire logic sw_rst, // Bench asks for a plain system reset.
  input wire logic cmp_en, // Comparator enable.
  input wire logic cmp_hysteresis_select, // Hysteresis select.
  input wire logic [umc_pkg::LEVEL_W-1:0] cmp_level, // Threshold code.
  input wire logic fuse_req, // Fuse read request.
  input wire logic bod_req, // Brown-out reset request.
  output logic cmp_out, // High while the supply is low.
  output logic fuse_rdy, // Fuse values valid.
  output logic sys_rst, // System reset.
  output logic sys_rst_bod // Reset came from brown-out.
);
  timeunit 1ns;
  timeprecision 1ns;
  import umc_pkg::*;
  logic [2:0] fcnt = 3'h0;
  logic [2:0] rcnt = 3'h0;
  logic bod_r = 1'b0;
  assign sys_rst_bod = bod_r;
  ////////////////////////////////////////////////////////////////////////////
  // With hysteresis the output holds high until the supply clears level plus one.
  always @(supply, cmp_en, cmp_hysteresis_select, cmp_level) begin
    if (!cmp_en) cmp_out = 1'b0;
    else if (supply < cmp_level) cmp_out = 1'b1;
    else if (!cmp_hysteresis_select || supply > cmp_level + 6'h01) cmp_out = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Fuses answer three cycles after a request, never at once.
  always @(posedge clk) begin
    if (!fuse_req) fcnt <= 3'h0;
    else if (fcnt != 3'h7) fcnt <= fcnt + 3'h1;
  end
  assign fuse_rdy = fcnt >= 3'h3;
  always @(posedge clk) begin
    if (rcnt != 3'h0) begin
      rcnt <= rcnt - 3'h1;
    end else if (bod_req || sw_rst) begin
      rcnt <= 3'h4;
      bod_r <= bod_req;
    end
  end
  assign sys_rst = rcnt != 3'h0;
endmodule : umc_far_model
`default_nettype wire

// file: verilog/umc_pkg.sv
`default_nettype none
package umc_pkg;
  // Register byte offsets on the bus.
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_UNLOCK = 8'h04;
  localparam logic [7:0] ADR_STAT = 8'h08;
  localparam logic [7:0] ADR_ISR = 8'h0C;
  localparam logic [7:0] ADR_IER = 8'h10;
  localparam logic [7:0] ADR_IDR = 8'h14;
  localparam logic [7:0] ADR_IMR = 8'h18;
  // Control register fields.
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_HYSTERESIS_SELECT_BIT = 3;
  localparam int CTRL_LEVEL_LSB = 4;
  localparam int LEVEL_W = 6;
  localparam int CTRL_FCD_BIT = 16;
  localparam int CTRL_FREEZE_BIT = 31;
  // Unlock word: key in the top byte, target offset in the low byte.
  localparam int UNLOCK_KEY_LSB = 24;
  localparam logic [7:0] UNLOCK_KEY = 8'hAA;
  // Status and interrupt bit positions.
  localparam int STAT_DET_BIT = 0;
  localparam int STAT_BLANK_BIT = 1;
  localparam int STAT_CAL_BIT = 2;
  localparam int IRQ_DET_BIT = 0;
  // Mode field encodings.
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_RESET = 2'h1;
  localparam logic [1:0] MODE_FLAG = 2'h2;
  // Reset values.
  localparam logic [LEVEL_W-1:0] LEVEL_RST = 6'h00;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
  // Blanking: half an RC period (115 kHz) plus two core clocks, rounded up.
  localparam int CLK_HZ = 10_000_000;
  localparam int RC_HZ = 115_000;
  localparam int NS_PER_S = 1_000_000_000;
  localparam int RC_HALF_NS = (NS_PER_S + 2 * RC_HZ - 1) / (2 * RC_HZ);
  localparam int CLK_NS = NS_PER_S / CLK_HZ;
  localparam int BLANK_EXTRA = 2;
  localparam int BLANK_CYC = (RC_HALF_NS + CLK_NS - 1) / CLK_NS + BLANK_EXTRA;
  localparam int BLANK_W = 7;
  localparam logic [BLANK_W-1:0] BLANK_LOAD = BLANK_W'(BLANK_CYC);
  typedef enum logic [1:0] {
    ST_CAL = 2'b01,
    ST_RUN = 2'b10
  } umc_state_t;
endpackage : umc_pkg
`default_nettype wire

// file: verilog/umc_top.sv
// Functional notes
// - The monitor leaves reset disabled and only runs once mode one or two is written or loaded from the fuses; a brown-out reset keeps the mode field.
// - A control write is dropped unless the unlock word for that register came just before.
// - Once the freeze bit is set every later control write is rejected.
// - The freeze bit clears after fuse calibration and any reset except a brown-out reset.
// - The level field picks the comparator threshold and the hysteresis bit adds hysteresis.
// - With mode one or two the detect flag follows the supply being below the threshold.
// - A rising detect flag raises an interrupt when its mask bit, set through enable, is set.
// - Mode one requests a brown-out reset on detection while mode two only flags it.
// - After enabling, the comparator is ignored for half an RC period plus two clocks.
// - While debug is enabled the brown-out reset and interrupt are suppressed.
// - After any reset but a brown-out reset with the done bit set, the mode, hysteresis and level fields are loaded from the fuses.
// - With the done bit clear at a reset, calibration reruns and sets it before code runs.
// - With the done bit set, calibration reruns after any reset but a brown-out reset.
// - The done bit clears at any non-brown-out reset and sets when fuse loading completes.
// - Software may overwrite the fuse-loaded fields through an accepted control write.
//
// Decided for this implementation: the Wishbone slave port and the register offsets.
`default_nettype none
module umc_top (
  input wire logic CORE_CLK, // Core clock, 10 MHz.
  input wire logic NRST, // Power-on reset, async, active low.
  input wire logic SYS_RST, // Synchronous system reset, active high.
  input wire logic SYS_RST_BOD, // System reset was caused by brown-out.
  input wire logic WB_CYC_I, // Bus cycle.
  input wire logic WB_STB_I, // Bus strobe.
  input wire logic WB_WE_I, // Bus write enable.
  input wire logic [7:0] WB_ADR_I, // Bus byte address.
  input wire logic [3:0] WB_SEL_I, // Bus byte lanes.
  input wire logic [31:0] WB_DAT_I, // Bus write data.
  output logic [31:0] WB_DAT_O, // Bus read data.
  output logic WB_ACK_O, // Bus acknowledge.
  input wire logic CMP_OUT, // Async comparator, high when supply is low.
  input wire logic DBG_EN, // Debug interface enabled.
  input wire logic FUSE_RDY, // Fuse values valid.
  input wire logic [1:0] FUSE_MODE, // Fuse mode value.
  input wire logic FUSE_HYSTERESIS_SELECT, // Fuse hysteresis value.
  input wire logic [umc_pkg::LEVEL_W-1:0] FUSE_LEVEL, // Fuse level value.
  output logic FUSE_REQ, // Fuse read request.
  output logic CPU_HOLD, // Hold processor until calibrated.
  output logic CMP_EN, // Comparator enable.
  output logic CMP_HYSTERESIS_SELECT, // Comparator hysteresis.
  output logic [umc_pkg::LEVEL_W-1:0] CMP_LEVEL, // Comparator threshold.
  output logic BOD_RST_REQ, // Brown-out reset request.
  output logic IRQ // Interrupt, level.
);
  import umc_pkg::*;

  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!NRST);

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] sel);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction : merge

  function automatic logic is_on(input logic [1:0] m);
    return (m == MODE_RESET) || (m == MODE_FLAG);
  endfunction : is_on

  ////////////////////////////////////////////////////////////////////////////
  umc_state_t state_r;
  logic [1:0] mode_r;
  logic hysteresis_select_r;
  logic [LEVEL_W-1:0] level_r;
  logic fcd_r;
  logic freeze_r;
  logic unlock_r;
  logic ack_r;
  logic [31:0] dat_r;
  logic cmp_s1_r;
  logic cmp_s2_r;
  logic en_d_r;
  logic [BLANK_W-1:0] blank_r;
  logic det_r;
  logic det_d_r;
  logic [31:0] isr_r;
  logic [31:0] imr_r;
  logic rst_r;
  logic wb_req;
  logic wb_wr;
  logic ctrl_wr_ok;
  logic en_now;
  logic active;
  logic det_rise;
  logic cal_load;
  logic [31:0] ctrl_word;
  logic [31:0] ctrl_nxt;
  logic [31:0] stat_word;

  assign wb_req = WB_CYC_I & WB_STB_I & ~ack_r;
  // A write lands on the edge at which the master samples ack, when its request is final.
  assign wb_wr = WB_CYC_I & WB_STB_I & WB_WE_I & ack_r;
  assign cal_load = (state_r == ST_CAL) & FUSE_RDY & ~SYS_RST;
  assign ctrl_wr_ok = wb_wr & (WB_ADR_I == ADR_CTRL) & unlock_r & ~freeze_r
                      & (state_r == ST_RUN);
  assign en_now = is_on(mode_r);
  // The first enabled cycle is masked as well, so the blanking is never short.
  assign active = en_now & en_d_r & (blank_r == '0);
  assign det_rise = det_r & ~det_d_r;

  always_comb begin
    ctrl_word = WORD_ZERO;
    ctrl_word[CTRL_MODE_LSB +: 2] = mode_r;
    ctrl_word[CTRL_HYSTERESIS_SELECT_BIT] = hysteresis_select_r;
    ctrl_word[CTRL_LEVEL_LSB +: LEVEL_W] = level_r;
    ctrl_word[CTRL_FCD_BIT] = fcd_r;
    ctrl_word[CTRL_FREEZE_BIT] = freeze_r;
    ctrl_nxt = merge(ctrl_word, WB_DAT_I, WB_SEL_I);
    stat_word = WORD_ZERO;
    stat_word[STAT_DET_BIT] = det_r;
    stat_word[STAT_BLANK_BIT] = en_now & ~active;
    stat_word[STAT_CAL_BIT] = (state_r == ST_CAL);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Calibration sequencer. A brown-out reset with the done bit set skips it.
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      state_r <= ST_CAL;
    end else if (SYS_RST) begin
      state_r <= (SYS_RST_BOD && fcd_r) ? ST_RUN : ST_CAL;
    end else begin
      case (state_r)
        ST_CAL: begin
          if (FUSE_RDY) begin
            state_r <= ST_RUN;
          end
        end
        ST_RUN: begin
          state_r <= ST_RUN;
        end
        default: begin
          state_r <= ST_CAL;
        end
      endcase
    end
  end

  assign FUSE_REQ = (state_r == ST_CAL) & ~SYS_RST;
  assign CPU_HOLD = (state_r == ST_CAL) | SYS_RST;

  // Control fields, done bit and freeze bit.
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      mode_r <= MODE_OFF;
      hysteresis_select_r <= 1'b0;
      level_r <= LEVEL_RST;
      fcd_r <= 1'b0;
      freeze_r <= 1'b0;
    end else if (SYS_RST) begin
      if (!SYS_RST_BOD) begin
        mode_r <= MODE_OFF;
        fcd_r <= 1'b0;
        freeze_r <= 1'b0;
      end
    end else if (cal_load) begin
      mode_r <= FUSE_MODE;
      hysteresis_select_r <= FUSE_HYSTERESIS_SELECT;
      level_r <= FUSE_LEVEL;
      fcd_r <= 1'b1;
      freeze_r <= 1'b0;
    end else if (ctrl_wr_ok) begin
      mode_r <= ctrl_nxt[CTRL_MODE_LSB +: 2];
      hysteresis_select_r <= ctrl_nxt[CTRL_HYSTERESIS_SELECT_BIT];
      level_r <= ctrl_nxt[CTRL_LEVEL_LSB +: LEVEL_W];
      freeze_r <= ctrl_nxt[CTRL_FREEZE_BIT];
    end
  end

  // Any bus write consumes the unlock, so it opens exactly one following write.
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      unlock_r <= 1'b0;
    end else if (SYS_RST) begin
      unlock_r <= 1'b0;
    end else if (wb_wr) begin
      unlock_r <= (WB_ADR_I == ADR_UNLOCK)
                  && (WB_DAT_I[UNLOCK_KEY_LSB +: 8] == UNLOCK_KEY)
                  && (WB_DAT_I[7:0] == ADR_CTRL);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Analog side. Level changes while enabled are the caller's hazard.
  assign CMP_EN = en_now;
  assign CMP_HYSTERESIS_SELECT = hysteresis_select_r;
  assign CMP_LEVEL = level_r;

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      cmp_s1_r <= 1'b0;
      cmp_s2_r <= 1'b0;
    end else begin
      cmp_s1_r <= CMP_OUT;
      cmp_s2_r <= cmp_s1_r;
    end
  end

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      en_d_r <= 1'b0;
      blank_r <= '0;
    end else begin
      en_d_r <= en_now;
      if (en_now && !en_d_r) begin
        blank_r <= BLANK_LOAD;
      end else if (!en_now) begin
        blank_r <= '0;
      end else if (blank_r != '0) begin
        blank_r <= blank_r - BLANK_W'(1);
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      det_r <= 1'b0;
      det_d_r <= 1'b0;
    end else if (SYS_RST) begin
      det_r <= 1'b0;
      det_d_r <= 1'b0;
    end else begin
      det_r <= active & cmp_s2_r;
      det_d_r <= det_r;
    end
  end

  // Reset request is registered so a comparator glitch cannot reach the reset tree.
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      rst_r <= 1'b0;
    end else begin
      rst_r <= (mode_r == MODE_RESET) & det_r & ~DBG_EN & ~SYS_RST;
    end
  end

  assign BOD_RST_REQ = rst_r;

  ////////////////////////////////////////////////////////////////////////////
  // Sticky status: a new edge in the same cycle as a clear still sets the bit.
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      isr_r <= WORD_ZERO;
    end else begin
      if (wb_wr && WB_ADR_I == ADR_ISR) begin
        isr_r <= isr_r & ~merge(WORD_ZERO, WB_DAT_I, WB_SEL_I);
      end
      if (det_rise && !DBG_EN) begin
        isr_r[IRQ_DET_BIT] <= 1'b1;
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      imr_r <= WORD_ZERO;
    end else if (wb_wr && WB_ADR_I == ADR_IER) begin
      imr_r[IRQ_DET_BIT] <= imr_r[IRQ_DET_BIT] | WB_DAT_I[IRQ_DET_BIT];
    end else if (wb_wr && WB_ADR_I == ADR_IDR) begin
      imr_r[IRQ_DET_BIT] <= imr_r[IRQ_DET_BIT] & ~WB_DAT_I[IRQ_DET_BIT];
    end
  end

  assign IRQ = |(isr_r & imr_r);

  ////////////////////////////////////////////////////////////////////////////
  // One wait state; unmapped addresses are acknowledged and read as zero.
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= wb_req;
    end
  end

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      dat_r <= WORD_ZERO;
    end else if (wb_req && !WB_WE_I) begin
      case (WB_ADR_I)
        ADR_CTRL: dat_r <= ctrl_word;
        ADR_STAT: dat_r <= stat_word;
        ADR_ISR: dat_r <= isr_r;
        ADR_IMR: dat_r <= imr_r;
        default: dat_r <= WORD_ZERO;
      endcase
    end
  end

  assign WB_ACK_O = ack_r;
  assign WB_DAT_O = dat_r;

  ////////////////////////////////////////////////////////////////////////////
  sequence en_rise_s;
    en_now && !en_d_r;
  endsequence

  sequence quiet_s;
    !det_r [*8];
  endsequence

  unlock_gate_a: assert property (
    (wb_wr && WB_ADR_I == ADR_CTRL && !unlock_r && !SYS_RST && !cal_load)
      |=> $stable(mode_r) && $stable(level_r) && $stable(hysteresis_select_r))
    else $error("Locked control write changed fields.");

  freeze_hold_a: assert property (
    (freeze_r && !SYS_RST && !cal_load) |=> $stable(mode_r) && $stable(level_r) && freeze_r)
    else $error("Frozen control register changed.");

  sync_path_a: assert property (
    $rose(det_r) |-> $past(cmp_s1_r, 2))
    else $error("Detect rose without a synchronised comparator level.");

  blank_start_a: assert property (
    en_rise_s |=> quiet_s)
    else $error("Detect set inside the blanking window.");

  blank_count_a: assert property (
    (blank_r != '0) |=> !det_r)
    else $error("Detect set while blanking counter runs.");

  det_mode_a: assert property (
    det_r |-> $past(is_on(mode_r)) && $past(cmp_s2_r))
    else $error("Detect flag set while monitor off or supply fine.");

  irq_rise_a: assert property (
    (det_rise && !DBG_EN) |=> isr_r[IRQ_DET_BIT] && (!imr_r[IRQ_DET_BIT] || IRQ))
    else $error("Detect edge did not raise the interrupt.");

  reset_mode_a: assert property (
    BOD_RST_REQ |-> $past(mode_r == MODE_RESET && det_r && !DBG_EN))
    else $error("Reset request without mode one detection.");

  debug_mask_a: assert property (
    DBG_EN [*2] |-> !BOD_RST_REQ && !$rose(isr_r[IRQ_DET_BIT]))
    else $error("Reset or interrupt escaped while debug enabled.");

  cal_load_a: assert property (
    cal_load |=> fcd_r && !freeze_r && mode_r == $past(FUSE_MODE)
      && level_r == $past(FUSE_LEVEL))
    else $error("Fuse values not loaded at calibration.");

  por_clear_a: assert property (
    (SYS_RST && !SYS_RST_BOD) |=> !fcd_r && !freeze_r && state_r == ST_CAL)
    else $error("Non brown-out reset kept done or freeze bit.");

  bod_keep_a: assert property (
    (SYS_RST && SYS_RST_BOD && fcd_r) |=> $stable(freeze_r) && $stable(level_r)
      && state_r == ST_RUN)
    else $error("Brown-out reset disturbed kept state.");

  det_follow_a: assert property (
    (active && cmp_s2_r && !SYS_RST) |=> det_r)
    else $error("Detect flag missed a low supply.");

  flag_no_reset_a: assert property (
    (mode_r != MODE_RESET) |=> !BOD_RST_REQ)
    else $error("Reset requested outside mode one.");

  hold_release_a: assert property (
    $fell(CPU_HOLD) |-> fcd_r && state_r == ST_RUN)
    else $error("Processor released before calibration was done.");

  isr_clear_a: assert property (
    (wb_wr && WB_ADR_I == ADR_ISR && WB_SEL_I[0] && WB_DAT_I[IRQ_DET_BIT]
      && !(det_rise && !DBG_EN)) |=> !isr_r[IRQ_DET_BIT])
    else $error("Interrupt status bit did not clear on a one.");

  mask_set_a: assert property (
    (wb_wr && WB_ADR_I == ADR_IER && WB_DAT_I[IRQ_DET_BIT]) |=> imr_r[IRQ_DET_BIT])
    else $error("Enable write did not set the mask bit.");

endmodule : umc_top
`default_nettype wire
